// ===== rtl/php_pkg.sv
// package of constants for the parallel host port
// Functional notes
// - accesses count only while port_select_n is low; may be tied low
// - separate read/write strobes or read_not_write with data_strobe_n
// - data bus is 16 bits wide or 8 bits on lower lines
// - decode: addr 0 write data, 0 read data, 1 command, 1 status
// - write with addr high restarts command; read with addr high does not
// - after command completes next written word is a command regardless
// - status bit0 hold_off, bit1 interrupt, bit2 command pending, 3-7 zero
// - status upper byte shows currently selected page number
// - hold_off polarity and drive mode programmable, undriven after reset
// - while hold_off active port is busy; host extends the access
// - data reads held off only when read data not yet available
// - status read after read command held off until data available
// - optional byte swap of data words
// - hold_off may assert from the write strobe falling edge
// - bus and hold_off undriven after reset; bus driven only on reads
// - each transaction is one command word then its data words
package php_pkg;
  // ---------------------------------------------------------------------
  // widths and layout
  // ---------------------------------------------------------------------
  localparam int        PHP_DW        = 16;
  localparam int        PHP_FIFO_D    = 8;
  localparam int        PHP_ST_HOLD   = 0;
  localparam int        PHP_ST_INT    = 1;
  localparam int        PHP_ST_CMD    = 2;
  localparam int        PHP_ST_PAGE   = 8;
  localparam logic [15:0] PHP_RST_STAT = 16'h0000;
  localparam logic [7:0]  PHP_RST_PAGE = 8'h00;
  // ---------------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------------
  localparam int        PHP_CLK_NS    = 25;
  localparam int        PHP_RDLAT_NS  = 270;
  localparam int        PHP_RDLAT_CYC = PHP_RDLAT_NS / PHP_CLK_NS;
endpackage

// ===== rtl/php_fifo.sv
// parameterised valid/ready fifo for the parallel host port
`timescale 1ns/100ps
`default_nettype none
module php_fifo #(
  parameter int W = 16,
  parameter int D = 8
) (
  input  wire logic         clk_sys,
  input  wire logic         rst,
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_ff [D];
  logic [AW-1:0] wp_ff;
  logic [AW-1:0] rp_ff;
  logic [AW:0]   cnt_ff;
  logic          push;
  logic          pop;
  // honest flags straight from the occupancy count; room while below depth
  assign in_ready  = (cnt_ff < (AW+1)'(D));
  assign out_valid = (cnt_ff != '0);
  assign out_data  = mem_ff[rp_ff];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  // storage
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_ff[wp_ff] <= in_data;
    end
  end
  // pointers and count
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wp_ff  <= '0;
      rp_ff  <= '0;
      cnt_ff <= '0;
    end else begin
      if (push) begin
        wp_ff <= wp_ff + 1'b1;
      end
      if (pop) begin
        rp_ff <= rp_ff + 1'b1;
      end
      cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
  cov_full_a: cover property (@(posedge clk_sys) cnt_ff == (AW+1)'(D));
  fifo_bound_a: assert property (@(posedge clk_sys) disable iff (rst)
    cnt_ff <= (AW+1)'(D)) else $error("fifo count overflow");
endmodule
`default_nettype wire

// ===== rtl/php_port.sv
// parallel host command port: pin front end, decode, fifo and status
`timescale 1ns/100ps
`default_nettype none
module php_port
  import php_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // host pins
  input  wire logic        port_select_n,
  input  wire logic        cmd_sel,
  input  wire logic        write_strobe_n,
  input  wire logic        read_strobe_n,
  input  wire logic [15:0] port_data_in,
  output logic [15:0]      port_data_out,
  output logic             port_data_oe,
  output logic             hold_off_out,
  output logic             hold_off_oe,
  // strap-style configuration
  input  wire logic        cfg_combined,
  input  wire logic        cfg_bus8,
  input  wire logic        cfg_swap,
  input  wire logic        cfg_hold_pol,
  input  wire logic        cfg_hold_en,
  input  wire logic        cfg_hold_opendrain,
  // core side
  input  wire logic        irq_state,
  output logic [15:0]      core_word,
  output logic             core_is_cmd,
  output logic             core_valid,
  input  wire logic        core_ready,
  input  wire logic        cmd_done,
  input  wire logic        page_set,
  input  wire logic [7:0]  page_num,
  input  wire logic        rd_data_valid,
  input  wire logic [15:0] rd_data,
  output logic             rd_data_take
);
  // ---------------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------------
  logic [1:0]  cs_s_ff;
  logic [1:0]  wr_s_ff;
  logic [1:0]  rd_s_ff;
  logic [1:0]  ad_s_ff;
  logic [15:0] d1_ff;
  logic [15:0] d2_ff;
  // two flops on every pin before any logic looks at it
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cs_s_ff <= 2'h3;
      wr_s_ff <= 2'h3;
      rd_s_ff <= 2'h3;
      ad_s_ff <= 2'h0;
      d1_ff   <= 16'h0000;
      d2_ff   <= 16'h0000;
    end else begin
      cs_s_ff <= {cs_s_ff[0], port_select_n};
      wr_s_ff <= {wr_s_ff[0], write_strobe_n};
      rd_s_ff <= {rd_s_ff[0], read_strobe_n};
      ad_s_ff <= {ad_s_ff[0], cmd_sel};
      d1_ff   <= port_data_in;
      d2_ff   <= d1_ff;
    end
  end

  // ---------------------------------------------------------------------
  // strobe decode
  // ---------------------------------------------------------------------
  logic act_w;
  logic is_rd_w;
  logic act_ff;
  logic rd_ff;
  logic ad_ff;
  logic [15:0] dat_ff;
  logic end_wr;
  logic start_rd;
  logic end_rd;
  // combined mode: second pin is read_not_write, first is data strobe
  always_comb begin
    if (cfg_combined) begin
      act_w   = !cs_s_ff[1] && !wr_s_ff[1];
      is_rd_w = rd_s_ff[1];
    end else begin
      act_w   = !cs_s_ff[1] && (!wr_s_ff[1] || !rd_s_ff[1]);
      is_rd_w = !rd_s_ff[1];
    end
  end
  // remember the access while it is active, so its end can be seen
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      act_ff <= 1'b0;
      rd_ff  <= 1'b0;
      ad_ff  <= 1'b0;
      dat_ff <= 16'h0000;
    end else begin
      act_ff <= act_w;
      if (act_w) begin
        rd_ff  <= is_rd_w;
        ad_ff  <= ad_s_ff[1];
        dat_ff <= d2_ff;
      end
    end
  end
  // data latched one cycle before the strobe is seen to end
  assign end_wr   = act_ff && !act_w && !rd_ff;
  assign start_rd = act_w && !act_ff && is_rd_w;
  assign end_rd   = act_ff && !act_w && rd_ff;

  // ---------------------------------------------------------------------
  // byte pairing and command framing
  // ---------------------------------------------------------------------
  logic       half_ff;
  logic [7:0] hi_ff;
  logic       rhalf_ff;
  logic       expect_cmd_ff;
  logic       cmd_pend_ff;
  logic [15:0] wword;
  logic       wfull;
  logic       wcmd;
  logic       push;
  logic       f_ready;
  // 8-bit mode: first byte is the high byte; 16-bit words pass at once
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      half_ff <= 1'b0;
      hi_ff   <= 8'h00;
    end else if (end_wr && cfg_bus8) begin
      if (ad_ff && !half_ff) begin
        half_ff <= 1'b1;
        hi_ff   <= dat_ff[7:0];
      end else begin
        half_ff <= !half_ff;
        hi_ff   <= dat_ff[7:0];
      end
    end
  end
  assign wfull = end_wr && (!cfg_bus8 || half_ff);
  always_comb begin
    if (cfg_bus8) begin
      wword = {hi_ff, dat_ff[7:0]};
    end else begin
      wword = dat_ff;
    end
  end
  // command words stay big-endian; only data is swapped
  assign wcmd = ad_ff || expect_cmd_ff;
  assign push = wfull && f_ready;
  // command framing: addr-high write restarts, completion re-arms
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      expect_cmd_ff <= 1'b1;
      cmd_pend_ff   <= 1'b0;
    end else if (push && wcmd) begin
      expect_cmd_ff <= 1'b0;
      cmd_pend_ff   <= 1'b1;
    end else if (cmd_done) begin
      expect_cmd_ff <= 1'b1;
      cmd_pend_ff   <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------
  // write fifo to the core
  // ---------------------------------------------------------------------
  logic [16:0] f_in;
  logic [16:0] f_out;
  assign f_in = {wcmd, (cfg_swap && !wcmd) ? {wword[7:0], wword[15:8]}
                                           : wword};
  php_fifo #(.W(17), .D(PHP_FIFO_D)) u_fifo (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .in_data   (f_in),
    .in_valid  (wfull),
    .in_ready  (f_ready),
    .out_data  (f_out),
    .out_valid (core_valid),
    .out_ready (core_ready)
  );
  assign core_word   = f_out[15:0];
  assign core_is_cmd = f_out[16];

  // ---------------------------------------------------------------------
  // status word and read path
  // ---------------------------------------------------------------------
  logic [7:0]  page_ff;
  logic        hold_ff;
  logic        hold_oe_ff;
  logic [15:0] dout_ff;
  logic        doe_ff;
  logic        rd_wait_ff;
  logic [15:0] status;
  logic        need_hold;
  // page number follows every select-page event
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      page_ff <= PHP_RST_PAGE;
    end else if (page_set) begin
      page_ff <= page_num;
    end
  end
  always_comb begin
    status = PHP_RST_STAT;
    status[PHP_ST_PAGE +: 8] = page_ff;
    status[PHP_ST_HOLD]      = hold_ff;
    status[PHP_ST_INT]       = irq_state;
    status[PHP_ST_CMD]       = cmd_pend_ff;
  end
  // any command word is outstanding until read data arrives or cmd_done
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rd_wait_ff <= 1'b0;
    end else if (push && wcmd) begin
      rd_wait_ff <= 1'b1;
    end else if (rd_data_valid || cmd_done) begin
      rd_wait_ff <= 1'b0;
    end
  end
  // hold on an unready data read, status read while waiting, or full fifo
  assign need_hold = cfg_hold_en && act_w &&
                     ((is_rd_w && rd_wait_ff && !rd_data_valid) ||
                      (!is_rd_w && !f_ready));
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      hold_ff    <= 1'b0;
      hold_oe_ff <= 1'b0;
    end else begin
      hold_ff    <= need_hold;
      hold_oe_ff <= cfg_hold_en && (!cfg_hold_opendrain || need_hold);
    end
  end
  assign hold_off_out = hold_ff ? cfg_hold_pol : !cfg_hold_pol;
  assign hold_off_oe  = hold_oe_ff;
  // drive the bus only during reads; upper byte first in 8-bit mode
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      doe_ff   <= 1'b0;
      dout_ff  <= 16'h0000;
      rhalf_ff <= 1'b0;
    end else begin
      doe_ff <= act_w && is_rd_w;
      if (act_w && is_rd_w) begin
        if (ad_s_ff[1]) begin
          dout_ff <= cfg_bus8 ? {8'h00, rhalf_ff ? status[7:0] : status[15:8]}
                              : status;
        end else begin
          dout_ff <= cfg_bus8 ? {8'h00, rhalf_ff ? rd_data[7:0] : rd_data[15:8]}
                              : (cfg_swap ? {rd_data[7:0], rd_data[15:8]}
                                          : rd_data);
        end
      end
      if (end_rd && cfg_bus8) begin
        rhalf_ff <= !rhalf_ff;
      end
    end
  end
  assign port_data_out = dout_ff;
  assign port_data_oe  = doe_ff;
  // a data read consumes the word after its last byte
  assign rd_data_take = end_rd && !ad_ff && (!cfg_bus8 || rhalf_ff);

  // ---------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------
  bus_idle_a: assert property (@(posedge clk_sys) disable iff (rst)
    !act_w |=> !port_data_oe) else $error("bus driven outside read");
  hold_rd_a: assert property (@(posedge clk_sys) disable iff (rst)
    (cfg_hold_en && act_w && is_rd_w && rd_wait_ff && !rd_data_valid)
    |=> hold_ff) else $error("missing hold on pending read");
  hold_free_a: assert property (@(posedge clk_sys) disable iff (rst)
    !cfg_hold_en |=> !hold_ff) else $error("hold while disabled");
  cmd_flag_a: assert property (@(posedge clk_sys) disable iff (rst)
    (push && wcmd) |=> cmd_pend_ff) else $error("command flag lost");
  cmd_rearm_a: assert property (@(posedge clk_sys) disable iff (rst)
    (cmd_done && !(push && wcmd)) |=> expect_cmd_ff)
    else $error("no rearm");
  stat_page_a: assert property (@(posedge clk_sys) disable iff (rst)
    page_set |=> status[15:8] == $past(page_num))
    else $error("page not shown");
  sel_gate_a: assert property (@(posedge clk_sys) disable iff (rst)
    cs_s_ff[1] |-> !act_w) else $error("access without select");
  stat_rsvd_a: assert property (@(posedge clk_sys) disable iff (rst)
    status[7:3] == 5'h00) else $error("reserved status bits set");
  cov_cmd_c: cover property (@(posedge clk_sys) push && wcmd);
  cov_hold_c: cover property (@(posedge clk_sys) hold_ff ##1 !hold_ff);
  cov_byte_c: cover property (@(posedge clk_sys) cfg_bus8 && wfull);
endmodule
`default_nettype wire

// ===== tb/php_host_model.sv
// host bus master model driving the parallel port pins
`timescale 1ns/100ps
`default_nettype none
module php_host_model (
  input  wire logic        clk_sys,
  input  wire logic        cfg_combined,
  input  wire logic        hold_busy,
  input  wire logic [15:0] port_data_out,
  input  wire logic        port_data_oe,
  output logic             port_select_n,
  output logic             cmd_sel,
  output logic             write_strobe_n,
  output logic             read_strobe_n,
  output logic [15:0]      port_data_in,
  output logic             saw_busy
);
  // ----------------------------------------------------------------
  // idle pins
  // ----------------------------------------------------------------
  initial begin
    port_select_n  = 1'b1;
    cmd_sel        = 1'b0;
    write_strobe_n = 1'b1;
    read_strobe_n  = 1'b1;
    port_data_in   = 16'h0000;
    saw_busy       = 1'b0;
  end

  // one access; held until hold-off clears, sampled 2 ns after a rising edge
  task automatic acc(input logic rd, input logic cs_n, input logic a,
                     input logic [15:0] d, output logic [15:0] q);
    int n = 0;
    @(posedge clk_sys) #2;
    saw_busy      = 1'b0;
    port_select_n = cs_n;
    cmd_sel       = a;
    // a read drives the complement of the last value, so no stale value lingers
    port_data_in  = rd ? ~port_data_in : d;
    if (cfg_combined) begin
      read_strobe_n  = rd;
      write_strobe_n = 1'b0;
    end else begin
      read_strobe_n  = ~rd;
      write_strobe_n = rd;
    end
    repeat (5) @(posedge clk_sys);
    // busy extends the access, bounded so a stuck pin cannot hang us
    while (hold_busy && n < 200) begin
      saw_busy = 1'b1;
      @(posedge clk_sys);
      n++;
    end
    repeat (2) @(posedge clk_sys);
    // sample off the edge so the registered read data has settled
    #2;
    q = port_data_oe ? port_data_out : 16'hxxxx;
    write_strobe_n = 1'b1;
    read_strobe_n  = 1'b1;
    port_select_n  = 1'b1;
    port_data_in   = ~port_data_in;
    repeat (4) @(posedge clk_sys);  // access spacing of 100 ns
  endtask
endmodule
`default_nettype wire

// ===== tb/php_port_tb.sv
// self-checking bench for the parallel host port
`timescale 1ns/100ps
`default_nettype none
module php_port_tb;
  import php_pkg::*;
  logic        clk_sys, rst, cfg_combined, cfg_bus8, cfg_swap;
  logic        cfg_hold_pol, cfg_hold_en, irq_state, core_ready;
  logic        cmd_done, page_set, rd_data_valid;
  logic [7:0]  page_num;
  logic [15:0] rd_data, rdq, port_data_in, port_data_out, core_word;
  logic        port_select_n, cmd_sel, write_strobe_n, read_strobe_n;
  logic        port_data_oe, hold_off_out, hold_off_oe, saw_busy;
  logic        core_is_cmd, core_valid, rd_data_take, hold_lvl, hold_busy;
  logic [16:0] popq[$];
  int          n_fail, cmp_count, take_n;

  // ----------------------------------------------------------------
  // clock, pull resistor on hold-off, core side capture
  // ----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // undriven hold-off is pulled to the inactive level
  assign hold_lvl  = hold_off_oe ? hold_off_out : ~cfg_hold_pol;
  assign hold_busy = (hold_lvl === cfg_hold_pol);
  always @(posedge clk_sys) begin
    if (core_valid === 1'b1 && core_ready === 1'b1)
      popq.push_back({core_is_cmd, core_word});
    if (rd_data_take === 1'b1)
      take_n++;
  end

  php_host_model i_host (.clk_sys(clk_sys), .cfg_combined(cfg_combined),
    .hold_busy(hold_busy), .port_data_out(port_data_out),
    .port_data_oe(port_data_oe), .port_select_n(port_select_n),
    .cmd_sel(cmd_sel), .write_strobe_n(write_strobe_n),
    .read_strobe_n(read_strobe_n), .port_data_in(port_data_in),
    .saw_busy(saw_busy));
  php_port i_dut (.clk_sys(clk_sys), .rst(rst),
    .port_select_n(port_select_n), .cmd_sel(cmd_sel),
    .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n),
    .port_data_in(port_data_in), .port_data_out(port_data_out),
    .port_data_oe(port_data_oe), .hold_off_out(hold_off_out),
    .hold_off_oe(hold_off_oe), .cfg_combined(cfg_combined),
    .cfg_bus8(cfg_bus8), .cfg_swap(cfg_swap), .cfg_hold_pol(cfg_hold_pol),
    .cfg_hold_en(cfg_hold_en), .cfg_hold_opendrain(1'b0),
    .irq_state(irq_state), .core_word(core_word),
    .core_is_cmd(core_is_cmd), .core_valid(core_valid),
    .core_ready(core_ready), .cmd_done(cmd_done), .page_set(page_set),
    .page_num(page_num), .rd_data_valid(rd_data_valid), .rd_data(rd_data),
    .rd_data_take(rd_data_take));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic tick();
    @(posedge clk_sys) #2;
  endtask
  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic a, input logic [15:0] d);
    i_host.acc(1'b0, 1'b0, a, d, rdq);
  endtask
  task automatic rd(input logic a);
    i_host.acc(1'b1, 1'b0, a, 16'h0000, rdq);
  endtask
  // waits a bounded time for the next word leaving the port
  task automatic pop(input logic [16:0] exp);
    int n = 0;
    while (popq.size() == 0 && n < 100) begin
      tick();
      n++;
    end
    chk((popq.size() != 0) ? popq.pop_front() : 17'hxxxxx, exp);
  endtask
  task automatic tdone(input string name);
    $display("test %s finished, mismatches so far %0d", name, n_fail);
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // a hang ends the run the same way as the tests
  initial begin
    #200000;
    n_fail++;
    tally_and_finish();
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    {cfg_combined, cfg_bus8, cfg_swap, cfg_hold_en} = 4'h0;
    {irq_state, cmd_done, page_set, rd_data_valid} = 4'h0;
    {cfg_hold_pol, core_ready} = 2'b11;
    {page_num, rd_data, n_fail, cmp_count, take_n} = '0;
    rst = 1'b1;
    repeat (3) @(posedge clk_sys);
    #2 rst = 1'b0;
    tick();
    chk({port_data_oe, hold_off_oe}, 17'h0);
    tdone("reset");
    irq_state = 1'b1;
    page_num  = 8'h5a;
    page_set  = 1'b1;
    tick();
    page_set  = 1'b0;
    wr(1'b1, 16'h0102);
    pop({1'b1, 16'h0102});
    rd(1'b1);
    chk(rdq, {8'h5a, 8'h06});
    wr(1'b0, 16'h1234);
    pop({1'b0, 16'h1234});
    cmd_done = 1'b1;
    tick();
    cmd_done = 1'b0;
    rd(1'b1);
    chk(rdq, {8'h5a, 8'h02});
    wr(1'b0, 16'h0203);
    pop({1'b1, 16'h0203});
    i_host.acc(1'b0, 1'b1, 1'b0, 16'h5555, rdq);
    chk(popq.size(), 17'h0);
    tdone("decode");
    cfg_swap = 1'b1;
    wr(1'b1, 16'h0a0b);
    pop({1'b1, 16'h0a0b});
    wr(1'b0, 16'h1234);
    pop({1'b0, 16'h3412});
    cfg_swap = 1'b0;
    cfg_bus8 = 1'b1;
    wr(1'b0, 16'hffab);
    wr(1'b0, 16'hffcd);
    pop({1'b0, 16'habcd});
    cfg_bus8 = 1'b0;
    cfg_combined = 1'b1;
    wr(1'b1, 16'h0c0d);
    pop({1'b1, 16'h0c0d});
    rd(1'b1);
    chk(rdq[15:8], 17'h5a);
    cfg_combined = 1'b0;
    tdone("swap_bus8_combined");
    cfg_hold_en = 1'b1;
    wr(1'b1, 16'h8001);
    pop({1'b1, 16'h8001});
    fork
      rd(1'b0);
      begin
        repeat (15) tick();
        rd_data       = 16'hbeef;
        rd_data_valid = 1'b1;
      end
    join
    rd_data_valid = 1'b0;
    chk(rdq, 16'hbeef);
    chk(saw_busy, 1'b1);
    chk(take_n, 17'h1);
    tdone("hold_off_read");
    // stalled core: ninth word finds the buffer full and is dropped
    cfg_hold_en = 1'b0;
    core_ready  = 1'b0;
    wr(1'b1, 16'h0e00);
    for (int i = 0; i < 8; i++)
      wr(1'b0, 16'(i));
    chk(popq.size(), 17'h0);
    core_ready = 1'b1;
    pop({1'b1, 16'h0e00});
    for (int i = 0; i < 7; i++)
      pop({1'b0, 16'(i)});
    repeat (10) tick();
    chk(popq.size(), 17'h0);
    tdone("fifo_fill");
    // no hold-off: host waits out the read latency before the data read
    wr(1'b1, 16'h8002);
    pop({1'b1, 16'h8002});
    rd_data       = 16'hc3c3;
    rd_data_valid = 1'b1;
    repeat (PHP_RDLAT_CYC + 1) tick();
    rd(1'b0);
    chk(rdq, 16'hc3c3);
    rd_data_valid = 1'b0;
    tdone("latency_read");
    tally_and_finish();
  end
endmodule
`default_nettype wire
